// >>> rtl/uerx_ctrl.sv
// Purpose: rx endpoint control/status logic for one usb endpoint
// Assumes: packet engine reports events as one-cycle pulses on CORE_CLK
// Notes: avalon-mm slave with one wait state on every access
// Contract
// - host mode: toggle writable only while toggle write enable is one
// - host mode: reading toggle bit returns the live data toggle
// - incomplete flag set on partial iso packet, cleared by zero, else reads zero
// - writing one to clear-toggle zeroes the toggle, zero leaves it
// - device mode: stall sent flag set on sent stall, cleared by zero
// - host mode: stall received flag set plus interrupt, cleared by zero
// - device mode: stall request bit makes endpoint answer with stall
// - host mode: in request starts in transaction, cleared on packet ready
// - flush discards packet, resets pointer, clears ready, self clears
// - device iso: error flag on bad packet, cleared with ready; bulk zero
// - host: error flag on bad data, bulk nak timeout flags and halts
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module uerx_ctrl (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [uerx_pkg::ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire uerx_pkg::uerx_link_ev_t LINK_EV,
   output uerx_pkg::uerx_link_cmd_t LINK_CMD,
   output logic IRQ
);
   import uerx_pkg::*;

   typedef struct packed {
      logic host_mode;
      logic iso_mode;
      logic [NAKLIM_W-1:0] nak_limit;
      logic toggle_write_enable;
      logic endpoint_toggle_state;
      logic incomplete_rx_packet;
      logic stall_flag;       // sent in device mode, received in host mode
      logic stall_ctl;        // stall request or in request by mode
      logic data_error;       // packet data error / data error or nak timeout
      logic receive_packet_ready;
      logic halted;
      logic flush_pulse;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic ack;              // one wait state, then answer
      logic [31:0] rdata;
      logic irq;
      uerx_link_cmd_t cmd;
   } uerx_st_t;

   uerx_st_t st_reg, st_next;
   logic nak_expired;
   logic [31:0] wmask;
   logic [31:0] csr_view;
   logic [31:0] cfg_view;
   logic wr_csr, wr_cfg, wr_stat, wr_mask;
   logic req;
   logic [IRQ_W-1:0] ev_irq;

   // nak limit only matters for host bulk reception
   uerx_nak_timer u_nak (
      .CORE_CLK(CORE_CLK),
      .RST(RST),
      .arm(st_reg.host_mode && !st_reg.iso_mode && st_reg.stall_ctl),
      .nak(LINK_EV.nak_rx),
      .restart(LINK_EV.pkt_done),
      .limit(st_reg.nak_limit),
      .expired(nak_expired)
   );

   // byte enables widened to a bit mask
   generate
      for (genvar i = 0; i < 4; i++) begin : g_be
         assign wmask[i*8 +: 8] = {8{AVS_BYTEENABLE[i]}};
      end
   endgenerate

   // read views; the toggle bit shows the live toggle state
   always_comb begin
      csr_view = '0;
      csr_view[B_TWEN] = st_reg.toggle_write_enable;
      csr_view[B_TGL] = st_reg.endpoint_toggle_state;
      csr_view[B_INCOMP] = st_reg.iso_mode && st_reg.incomplete_rx_packet;
      csr_view[B_STALL_ST] = st_reg.stall_flag;
      csr_view[B_STALL_CTL] = st_reg.stall_ctl;
      // device bulk reads zero; host keeps its error flag
      csr_view[B_DERR] = st_reg.data_error &&
         (st_reg.host_mode || st_reg.iso_mode);
      csr_view[B_RXRDY] = st_reg.receive_packet_ready;
      cfg_view = '0;
      cfg_view[B_HOST] = st_reg.host_mode;
      cfg_view[B_ISO] = st_reg.iso_mode;
      cfg_view[B_NAKLIM +: NAKLIM_W] = st_reg.nak_limit;
   end

   // a request is taken once; the ack cycle blocks a second take of it
   assign req = (AVS_READ || AVS_WRITE) && !st_reg.ack;
   assign wr_csr = req && AVS_WRITE && AVS_ADDRESS == OFF_CSR;
   assign wr_cfg = req && AVS_WRITE && AVS_ADDRESS == OFF_CFG;
   assign wr_stat = req && AVS_WRITE && AVS_ADDRESS == OFF_IRQ_STAT;
   assign wr_mask = req && AVS_WRITE && AVS_ADDRESS == OFF_IRQ_MASK;

   // events that raise sticky interrupt status
   always_comb begin
      ev_irq = '0;
      ev_irq[I_STALL] = st_reg.host_mode ? LINK_EV.stall_rx : 1'b0;
      ev_irq[I_RXRDY] = LINK_EV.pkt_done;
      ev_irq[I_ERR] = nak_expired || (LINK_EV.pkt_done && LINK_EV.crc_err);
   end

   // next state: bus writes first, hardware events override (set wins)
   always_comb begin
      st_next = st_reg;
      st_next.flush_pulse = 1'b0;
      st_next.ack = req;
      // configuration
      if (wr_cfg && AVS_BYTEENABLE[0]) begin
         st_next.host_mode = AVS_WRITEDATA[B_HOST];
         st_next.iso_mode = AVS_WRITEDATA[B_ISO];
      end
      if (wr_cfg) begin
         st_next.nak_limit = (AVS_WRITEDATA[B_NAKLIM +: NAKLIM_W] &
            wmask[B_NAKLIM +: NAKLIM_W]) |
            (st_reg.nak_limit & ~wmask[B_NAKLIM +: NAKLIM_W]);
      end
      // control/status word, upper bytes only hold writable fields
      if (wr_csr && AVS_BYTEENABLE[3]) begin
         st_next.toggle_write_enable = AVS_WRITEDATA[B_TWEN];
         if (st_reg.host_mode && st_reg.toggle_write_enable) begin
            st_next.endpoint_toggle_state = AVS_WRITEDATA[B_TGL];
         end
         if (!AVS_WRITEDATA[B_INCOMP]) begin
            st_next.incomplete_rx_packet = 1'b0;
         end
         if (AVS_WRITEDATA[B_CLEAR_TOGGLE_REQUEST]) begin
            st_next.endpoint_toggle_state = 1'b0;
         end
      end
      if (wr_csr && AVS_BYTEENABLE[2]) begin
         if (!AVS_WRITEDATA[B_STALL_ST]) begin
            st_next.stall_flag = 1'b0;
         end
         st_next.stall_ctl = AVS_WRITEDATA[B_STALL_CTL];
         if (AVS_WRITEDATA[B_STALL_CTL]) begin
            st_next.halted = 1'b0; // new in request restarts halted endpoint
         end
         if (!AVS_WRITEDATA[B_DERR] && st_reg.host_mode) begin
            st_next.data_error = 1'b0;
         end
         if (AVS_WRITEDATA[B_FLUSH]) begin
            // drop the packet; flush is a pulse so the bit never sticks
            st_next.flush_pulse = 1'b1;
            st_next.receive_packet_ready = 1'b0;
         end
      end
      // interrupt status and mask
      if (wr_stat && AVS_BYTEENABLE[0]) begin
         st_next.irq_stat = st_reg.irq_stat & ~AVS_WRITEDATA[IRQ_W-1:0];
      end
      if (wr_mask && AVS_BYTEENABLE[0]) begin
         st_next.irq_mask = AVS_WRITEDATA[IRQ_W-1:0];
      end
      // software unload clears ready, and the device data error with it
      if (LINK_EV.unload) begin
         st_next.receive_packet_ready = 1'b0;
      end
      if (!st_next.receive_packet_ready && !st_reg.host_mode) begin
         st_next.data_error = 1'b0;
      end
      // hardware events win over clears in the same cycle
      if (LINK_EV.pkt_done) begin
         st_next.receive_packet_ready = 1'b1;
         if (st_reg.host_mode) begin
            st_next.stall_ctl = 1'b0;
         end
         if (LINK_EV.crc_err && (st_reg.host_mode || st_reg.iso_mode)) begin
            st_next.data_error = 1'b1;
         end
         if (LINK_EV.pkt_partial && st_reg.iso_mode) begin
            st_next.incomplete_rx_packet = 1'b1;
         end
      end
      if (st_reg.host_mode ? LINK_EV.stall_rx : LINK_EV.stall_tx) begin
         st_next.stall_flag = 1'b1;
      end
      if (nak_expired) begin
         st_next.data_error = 1'b1;
         st_next.halted = 1'b1;
         st_next.stall_ctl = 1'b0;
      end
      st_next.irq_stat = st_next.irq_stat | ev_irq;
      // read data, unmapped addresses read zero
      st_next.rdata = '0;
      if (req && AVS_READ) begin
         unique case (AVS_ADDRESS)
            OFF_CSR: st_next.rdata = csr_view;
            OFF_CFG: st_next.rdata = cfg_view;
            OFF_IRQ_STAT: st_next.rdata[IRQ_W-1:0] = st_reg.irq_stat;
            OFF_IRQ_MASK: st_next.rdata[IRQ_W-1:0] = st_reg.irq_mask;
            default: st_next.rdata = '0;
         endcase
      end
      st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
      // link commands by mode
      st_next.cmd.stall_active = !st_next.host_mode && st_next.stall_ctl;
      st_next.cmd.in_request = st_next.host_mode && st_next.stall_ctl &&
         !st_next.halted;
      st_next.cmd.rx_halted = st_next.halted;
      st_next.cmd.toggle = st_next.endpoint_toggle_state;
      st_next.cmd.fifo_flush = st_next.flush_pulse;
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from state flops
   assign AVS_READDATA = st_reg.rdata;
   assign AVS_WAITREQUEST = !st_reg.ack;
   assign LINK_CMD = st_reg.cmd;
   assign IRQ = st_reg.irq;

   // read-side checks look at the registered read data, not the view
   toggle_lock_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      wr_csr && AVS_BYTEENABLE[3] && !st_reg.toggle_write_enable &&
      !AVS_WRITEDATA[B_CLEAR_TOGGLE_REQUEST] && !(AVS_WRITEDATA[B_TGL] ==
      st_reg.endpoint_toggle_state) |=> $stable(st_reg.endpoint_toggle_state))
      else $error("toggle changed while write locked");
   toggle_view_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      req && AVS_READ && AVS_ADDRESS == OFF_CSR |=>
      AVS_READDATA[B_TGL] == $past(st_reg.endpoint_toggle_state))
      else $error("toggle read view wrong");
   incomp_bulk_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      req && AVS_READ && AVS_ADDRESS == OFF_CSR && !st_reg.iso_mode
      |=> !AVS_READDATA[B_INCOMP])
      else $error("incomplete flag seen outside iso");
   clr_toggle_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      wr_csr && AVS_BYTEENABLE[3] && AVS_WRITEDATA[B_CLEAR_TOGGLE_REQUEST]
      |=> !LINK_CMD.toggle ##0 !st_reg.endpoint_toggle_state)
      else $error("clear toggle failed");
   stall_sent_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      !st_reg.host_mode && LINK_EV.stall_tx |=> st_reg.stall_flag)
      else $error("stall sent not flagged");
   stall_irq_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      st_reg.host_mode && LINK_EV.stall_rx && st_reg.irq_mask[I_STALL]
      |=> IRQ && st_reg.stall_flag)
      else $error("stall received without interrupt");
   // status set must survive a write-one clear in the same cycle
   stat_set_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      ev_irq != '0 |=> (st_reg.irq_stat & $past(ev_irq)) == $past(ev_irq))
      else $error("event lost against status clear");
   stall_cmd_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      LINK_CMD.stall_active |-> !st_reg.host_mode && st_reg.stall_ctl)
      else $error("stall issued without request");
   inreq_clr_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      st_reg.host_mode && LINK_EV.pkt_done
      |=> !LINK_CMD.in_request && st_reg.receive_packet_ready)
      else $error("in request not cleared by packet ready");
   flush_pulse_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      LINK_CMD.fifo_flush |=> !LINK_CMD.fifo_flush)
      else $error("flush did not self clear");
   // a packet landing with the flush wins, so it is left out here
   flush_rdy_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      wr_csr && AVS_BYTEENABLE[2] && AVS_WRITEDATA[B_FLUSH] &&
      !LINK_EV.pkt_done |=> LINK_CMD.fifo_flush &&
      !st_reg.receive_packet_ready)
      else $error("flush left packet ready");
   derr_bulk_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      req && AVS_READ && AVS_ADDRESS == OFF_CSR && !st_reg.host_mode &&
      !st_reg.iso_mode |=> !AVS_READDATA[B_DERR])
      else $error("device bulk data error visible");
   nak_halt_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      nak_expired |=> st_reg.halted && st_reg.data_error)
      else $error("nak timeout did not halt");
   rdy_set_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      LINK_EV.pkt_done |=> st_reg.receive_packet_ready)
      else $error("packet ready not set");
   shared_bit_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      LINK_CMD.in_request |-> !LINK_CMD.stall_active)
      else $error("shared bit used in both senses");
   wait_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus answer late");

   cov_flush_c: cover property (@(posedge CORE_CLK) LINK_CMD.fifo_flush);
   cov_nak_c: cover property (@(posedge CORE_CLK) nak_expired);
   cov_stall_c: cover property (@(posedge CORE_CLK)
      st_reg.host_mode && LINK_EV.stall_rx);
   cov_setclr_c: cover property (@(posedge CORE_CLK)
      LINK_EV.pkt_done && LINK_EV.unload);
endmodule : uerx_ctrl

// >>> rtl/uerx_pkg.sv
// Purpose: shared constants and carrier types for the usb rx endpoint block
// Assumes: 32-bit avalon-mm register port, word addressing by byte offset
// Notes: bit positions follow the endpoint rx control/status word
package uerx_pkg;
   localparam int ADDR_W = 4;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CSR = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_CFG = 4'hc;
   // control/status field positions
   localparam int B_TWEN = 26;
   localparam int B_TGL = 25;
   localparam int B_INCOMP = 24;
   localparam int B_CLEAR_TOGGLE_REQUEST = 23;
   localparam int B_STALL_ST = 22;
   localparam int B_STALL_CTL = 21;
   localparam int B_FLUSH = 20;
   localparam int B_DERR = 19;
   localparam int B_RXRDY = 0;
   // configuration register fields
   localparam int B_HOST = 0;
   localparam int B_ISO = 1;
   localparam int B_NAKLIM = 8;
   localparam int NAKLIM_W = 16;
   // interrupt status fields
   localparam int I_STALL = 0;
   localparam int I_RXRDY = 1;
   localparam int I_ERR = 2;
   localparam int IRQ_W = 3;
   // reset values
   localparam logic [31:0] CSR_RST = 32'h0000_0000;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [NAKLIM_W-1:0] NAKLIM_RST = 16'h0000;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   // events reported by the usb packet engine
   typedef struct packed {
      logic pkt_done;     // complete packet landed in the rx fifo
      logic pkt_partial;  // high-bandwidth packet with missing data
      logic crc_err;      // crc or bit-stuff error on that packet
      logic stall_tx;     // stall handshake sent (device mode)
      logic stall_rx;     // stall handshake received (host mode)
      logic nak_rx;       // nak handshake received (host mode)
      logic unload;       // software unloaded the packet from the fifo
   } uerx_link_ev_t;

   // commands to the usb packet engine and fifo
   typedef struct packed {
      logic stall_active; // answer with stall handshakes
      logic in_request;   // issue in tokens
      logic rx_halted;    // endpoint halted by nak timeout
      logic toggle;       // current data toggle
      logic fifo_flush;   // one-cycle flush pulse
   } uerx_link_cmd_t;
endpackage : uerx_pkg

// >>> rtl/uerx_nak_timer.sv
// Purpose: nak limit timer for host bulk receive
// Assumes: nak_rx pulses once per nak, any data or stop clears the count
// Notes: counts naks, not time; limit zero disables the timer
`timescale 1ns/1ps
module uerx_nak_timer (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic arm,
   input wire logic nak,
   input wire logic restart,
   input wire logic [uerx_pkg::NAKLIM_W-1:0] limit,
   output logic expired
);
   import uerx_pkg::*;

   typedef struct packed {
      logic [NAKLIM_W-1:0] cnt;
      logic expired;
   } uerx_nak_st_t;

   uerx_nak_st_t st_reg, st_next;

   // count consecutive naks while armed, pulse at the limit
   always_comb begin
      st_next = st_reg;
      st_next.expired = 1'b0;
      if (!arm || restart) begin
         st_next.cnt = '0;
      end else if (nak && limit != '0) begin
         if (st_reg.cnt + 16'h0001 >= limit) begin
            st_next.cnt = '0;
            st_next.expired = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign expired = st_reg.expired;

   nak_limit_a: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      st_reg.expired |-> $past(arm) && $past(nak))
      else $error("nak timeout without a nak");
endmodule : uerx_nak_timer

// >>> testbench/uerx_peer.sv
// Purpose: behavioural usb peer feeding the packet engine event port
// Assumes: events are one-cycle pulses on CORE_CLK
// Notes: mode 1 answers in tokens with data, mode 2 with naks
`timescale 1ns/1ps
module uerx_peer (
   input wire logic clk,
   input wire logic rst,
   input wire uerx_pkg::uerx_link_cmd_t cmd,
   input wire uerx_pkg::uerx_link_ev_t ev_req,
   input wire logic [1:0] mode,
   output uerx_pkg::uerx_link_ev_t ev
);
   import uerx_pkg::*;
   logic [3:0] gap_reg;
   // a slow peer: each answer comes sixteen cycles apart while requested
   always_ff @(posedge clk) begin
      ev <= ev_req;
      gap_reg <= 4'h0;
      if (!rst && cmd.in_request) begin
         gap_reg <= gap_reg + 4'h1;
         if (gap_reg == 4'h7) begin
            ev.pkt_done <= (mode == 2'h1);
            ev.nak_rx <= (mode == 2'h2);
         end
      end
   end
endmodule : uerx_peer

// >>> testbench/tb_top.sv
// Purpose: self-checking bench for the rx endpoint control block
// Assumes: avalon-mm master tasks, peer model on the event port
// Notes: each scenario leaves the block idle for the next one
`timescale 1ns/1ps
module tb_top;
   import uerx_pkg::*;
   localparam logic [6:0] E_DONE = 7'h40;
   localparam logic [6:0] E_PART = 7'h20;
   localparam logic [6:0] E_CRC = 7'h10;
   localparam logic [6:0] E_ST = 7'h08;
   localparam logic [6:0] E_SR = 7'h04;
   localparam logic [6:0] E_UNL = 7'h01;
   logic CORE_CLK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ;
   logic [3:0] AVS_ADDRESS, AVS_BYTEENABLE;
   logic [31:0] AVS_WRITEDATA, AVS_READDATA;
   uerx_link_ev_t ev_req, link_ev;
   uerx_link_cmd_t link_cmd;
   logic [1:0] peer_mode;
   int n_fail, n_checks, cyc, flushes;
   uerx_ctrl dut (.CORE_CLK(CORE_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .LINK_EV(link_ev), .LINK_CMD(link_cmd), .IRQ(IRQ));
   uerx_peer peer (.clk(CORE_CLK), .rst(RST), .cmd(link_cmd),
      .ev_req(ev_req), .mode(peer_mode), .ev(link_ev));
   // 125 MHz core clock
   initial begin
      CORE_CLK = 1'b0;
      forever #4 CORE_CLK = ~CORE_CLK;
   end
   // hang guard and flush pulse counter
   always @(posedge CORE_CLK) begin
      cyc++;
      if (link_cmd.fifo_flush === 1'b1) flushes++;
      if (cyc == 5000) begin
         n_fail++;
         stop_test();
      end
   end
   task stop_test;
      if (n_fail == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
      n_checks++;
      if (seen !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
      end
   endtask : chk
   // one bus cycle; request held until waitrequest is sampled low
   // no local cap: only the bench timeout may end a wait
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_BYTEENABLE <= be;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      do begin
         @(posedge CORE_CLK);
      end while (AVS_WAITREQUEST !== 1'b0);
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      @(posedge CORE_CLK);
   endtask : bus
   task wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hf, q);
   endtask : wr
   task rc(input string nm, input logic [3:0] a, input logic [31:0] m,
      input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hf, q);
      chk(nm, q & m, e);
   endtask : rc
   task fire(input logic [6:0] e);
      ev_req <= uerx_link_ev_t'(e);
      @(posedge CORE_CLK);
      ev_req <= '0;
      repeat (2) @(posedge CORE_CLK);
   endtask : fire
   task t_reset;
      logic [31:0] q;
      rc("csr", OFF_CSR, 32'hffff_ffff, CSR_RST);
      rc("cfg", OFF_CFG, 32'hffff_ffff, CFG_RST);
      rc("stat", OFF_IRQ_STAT, 32'hffff_ffff, 32'h0);
      wr(4'h2, 32'hffff_ffff);
      rc("unmapped", 4'h2, 32'hffff_ffff, 32'h0);
      bus(1'b1, OFF_IRQ_MASK, 32'hffff_ffff, 4'h0, q);
      rc("lanes", OFF_IRQ_MASK, 32'hffff_ffff, 32'h0);
      chk("irq", IRQ, 32'h0);
   endtask : t_reset
   // old enable value governs the toggle write
   task t_toggle;
      wr(OFF_CFG, 32'h1);
      wr(OFF_CSR, 32'h0200_0000);
      rc("tgl locked", OFF_CSR, 32'h0200_0000, 32'h0);
      wr(OFF_CSR, 32'h0400_0000);
      wr(OFF_CSR, 32'h0200_0000);
      rc("tgl set", OFF_CSR, 32'h0600_0000, 32'h0200_0000);
      wr(OFF_CSR, 32'h0);
      rc("tgl kept", OFF_CSR, 32'h0280_0000, 32'h0200_0000);
      chk("cmd tgl", link_cmd.toggle, 32'h1);
      wr(OFF_CSR, 32'h0080_0000);
      rc("tgl clr", OFF_CSR, 32'h0280_0000, 32'h0);
      chk("cmd tgl0", link_cmd.toggle, 32'h0);
   endtask : t_toggle
   // stall received in host mode: masked, unmasked, cleared
   task t_host_stall;
      wr(OFF_IRQ_MASK, 32'h0);
      fire(E_SR);
      rc("stall_received_flag", OFF_CSR, 32'h0040_0000, 32'h0040_0000);
      rc("stat0", OFF_IRQ_STAT, 32'h7, 32'h1);
      chk("irq masked", IRQ, 32'h0);
      wr(OFF_IRQ_MASK, 32'h1);
      chk("irq on", IRQ, 32'h1);
      wr(OFF_CSR, 32'h0);
      rc("stall_received_flag clr", OFF_CSR, 32'h0040_0000, 32'h0);
      wr(OFF_IRQ_STAT, 32'h7);
      chk("irq off", IRQ, 32'h0);
      // a stall arriving while unmasked raises the line at once
      fire(E_SR);
      chk("irq again", IRQ, 32'h1);
      rc("stall_received_flag again", OFF_CSR, 32'h0040_0000, 32'h0040_0000);
      wr(OFF_IRQ_STAT, 32'h7);
   endtask : t_host_stall
   task t_in_req;
      int f0;
      peer_mode <= 2'h1;
      wr(OFF_CSR, 32'h0020_0000);
      chk("in req", link_cmd.in_request, 32'h1);
      chk("no stall", link_cmd.stall_active, 32'h0);
      repeat (16) @(posedge CORE_CLK);
      rc("req done", OFF_CSR, 32'h0020_0001, 32'h1);
      peer_mode <= 2'h0;
      f0 = flushes;
      wr(OFF_CSR, 32'h0010_0000);
      chk("flush pulse", flushes - f0, 32'h1);
      rc("flushed", OFF_CSR, 32'h0010_0001, 32'h0);
      fire(E_DONE | E_CRC);
      rc("host derr", OFF_CSR, 32'h0008_0001, 32'h0008_0001);
      wr(OFF_CSR, 32'h0);
      rc("derr clr", OFF_CSR, 32'h0008_0000, 32'h0);
      fire(E_UNL);
      rc("unloaded", OFF_CSR, 32'h1, 32'h0);
      wr(OFF_IRQ_STAT, 32'h7);
   endtask : t_in_req
   // nak limit of three, peer keeps answering nak
   task t_nak;
      wr(OFF_CFG, 32'h0000_0301);
      peer_mode <= 2'h2;
      wr(OFF_CSR, 32'h0020_0000);
      repeat (120) @(posedge CORE_CLK);
      chk("halted", link_cmd.rx_halted, 32'h1);
      chk("req gone", link_cmd.in_request, 32'h0);
      rc("nak derr", OFF_CSR, 32'h0028_0000, 32'h0008_0000);
      rc("nak stat", OFF_IRQ_STAT, 32'h4, 32'h4);
      peer_mode <= 2'h0;
      wr(OFF_IRQ_STAT, 32'h7);
   endtask : t_nak
   task t_dev_stall;
      wr(OFF_CFG, 32'h0);
      wr(OFF_CSR, 32'h0020_0000);
      chk("stall on", link_cmd.stall_active, 32'h1);
      chk("no in", link_cmd.in_request, 32'h0);
      fire(E_ST);
      rc("sent", OFF_CSR, 32'h0060_0000, 32'h0060_0000);
      wr(OFF_CSR, 32'h0);
      chk("stall off", link_cmd.stall_active, 32'h0);
      rc("sent clr", OFF_CSR, 32'h0060_0000, 32'h0);
   endtask : t_dev_stall
   // iso flags set and cleared, bulk flags stay zero
   task t_iso;
      wr(OFF_CFG, 32'h2);
      fire(E_DONE | E_PART | E_CRC);
      rc("iso", OFF_CSR, 32'h0108_0001, 32'h0108_0001);
      fire(E_UNL);
      rc("iso unl", OFF_CSR, 32'h0108_0001, 32'h0100_0000);
      wr(OFF_CSR, 32'h0);
      rc("inc clr", OFF_CSR, 32'h0100_0000, 32'h0);
      wr(OFF_CFG, 32'h0);
      fire(E_DONE | E_PART | E_CRC);
      rc("bulk", OFF_CSR, 32'h0108_0000, 32'h0);
      fire(E_UNL);
   endtask : t_iso
   // reset, then the scenarios in turn
   initial begin
      RST = 1'b1;
      AVS_READ = 1'b0;
      AVS_WRITE = 1'b0;
      AVS_ADDRESS = 4'h0;
      AVS_BYTEENABLE = 4'h0;
      AVS_WRITEDATA = 32'h0;
      ev_req = '0;
      peer_mode = 2'h0;
      repeat (8) @(posedge CORE_CLK);
      RST <= 1'b0;
      @(posedge CORE_CLK);
      t_reset();
      t_toggle();
      t_host_stall();
      t_in_req();
      t_nak();
      t_dev_stall();
      t_iso();
      stop_test();
   end
endmodule : tb_top
